// file: verilog/tafo_pkg.sv
package tafo_pkg;

  // register indices; byte address on the bus is four times the index
  localparam logic [7:0] OFF_FAN_POLICY = 8'h10;
  localparam logic [7:0] OFF_HYST       = 8'h11;
  localparam logic [7:0] OFF_CRIT_R1    = 8'h6A;
  localparam logic [7:0] OFF_CRIT_LOC   = 8'h6B;
  localparam logic [7:0] OFF_CRIT_R2    = 8'h6C;
  localparam logic [7:0] OFF_MASK1      = 8'h74;
  localparam logic [7:0] OFF_MASK2      = 8'h75;
  localparam logic [7:0] OFF_CFG3       = 8'h78;
  localparam logic [7:0] OFF_TIMER      = 8'h79;
  localparam logic [7:0] OFF_TLIM       = 8'h7A;
  localparam logic [7:0] OFF_OUT_EN     = 8'h7C;
  localparam logic [7:0] OFF_PIN_CFG    = 8'h7D;
  localparam logic [7:0] OFF_ISR2       = 8'h80;
  localparam logic [7:0] OFF_MISC       = 8'h81;

  localparam logic [7:0] RST_REG = 8'h00;

  // field positions
  localparam int TMR_EN_BIT     = 1;  // monitor_config_three
  localparam int FAN_OVERRIDE_BIT_BIT      = 2;  // monitor_config_three
  localparam int MANUAL_OK_BIT  = 3;  // fan_policy_config
  localparam int HYST_OFF_BIT   = 0;  // hysteresis_config
  localparam int OVH_DIS_BIT    = 2;  // pin_and_override_config
  localparam int MAX_DUTY_BIT   = 3;  // pin_and_override_config
  localparam int SEL_LSB        = 0;  // pin_and_override_config [1:0]
  localparam int CH_EN_LSB      = 5;  // channel_output_enable [7:5]
  localparam int MASK1_TMR_BIT  = 0;
  localparam int MASK2_TMR_BIT  = 5;
  localparam int TLIM_FLAG_BIT  = 5;  // interrupt status two
  localparam int OFF64_BIT      = 0;  // misc: offset-64 temperature format
  localparam int HIFREQ_BIT     = 4;  // misc: high pwm frequency
  localparam int LOFREQ_LSB     = 5;  // misc [7:5]: low frequency option

  typedef enum logic [1:0] {
    TAFO_SEL_SPEED = 2'b00,
    TAFO_SEL_OVH   = 2'b01,
    TAFO_SEL_ALERT = 2'b10,
    TAFO_SEL_GPIO  = 2'b11
  } tafo_sel_t;

  localparam logic [7:0] DUTY_FULL    = 8'hFF;
  localparam logic [7:0] OFF64_MIN    = 8'h01;  // -63 in offset-64 code
  localparam logic [7:0] TWOS_MIN     = 8'h80;  // -128 in twos complement

  // timer resolution
  localparam int TIMER_LSB_US = 22760;
  localparam int CLK_MHZ      = 40;
  localparam int TICK_CYC     = TIMER_LSB_US * CLK_MHZ;
  localparam int PRESC_W      = 24;

  typedef struct packed {
    logic [9:0] address;
    logic       read;
    logic       write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } tafo_avs_req_t;

  // temperatures: 8-bit code plus two quarter-degree bits
  typedef struct packed {
    logic [2:0][9:0] temp;
    logic            cycle_done;
  } tafo_temp_in_t;

  typedef struct packed {
    logic [2:0][7:0] duty;
    logic [2:0][7:0] max_duty;
    logic            manual;
  } tafo_fan_in_t;

  typedef struct packed {
    logic [7:0] fan_policy;
    logic [7:0] hyst;
    logic [2:0][7:0] crit;
    logic [7:0] mask1;
    logic [7:0] mask2;
    logic [7:0] cfg3;
    logic [7:0] tlim;
    logic [7:0] out_en;
    logic [7:0] pin_cfg;
    logic [7:0] misc;
    logic       isr_flag;
    logic [1:0] ded_sync;
    logic [1:0] sh_sync;
    logic       seen;
    logic [7:0] units;
    logic [PRESC_W-1:0] presc;
    logic [2:0] ovh_ch;
    logic [2:0][7:0] duty;
    logic       ack;
    logic [31:0] rdata;
  } tafo_state_t;

endpackage

// file: verilog/tafo_top.sv
`timescale 1ns/1ps

// Notes on behaviour
// R01: timer monitoring only with config three bit1
// R02: shared pin overheat needs enable bit too
// R03: override drives running fans full while asserted
// R04: override clear leaves fan duty untouched
// R05: per-pin mask bit suppresses timer alert
// R06: zero limit alerts on first assertion
// R07: pull line low above limit plus quarter
// R08: hold low until temperature at/below limit
// R09: low at least one monitoring cycle
// R10: three critical limits at consecutive offsets
// R11: per-channel output enables, bits five to seven
// R12: very low limit disables that channel
// R13: hysteresis config bit0 turns hysteresis off
// R14: hysteresis on plus disable: no pull
// R15: hysteresis off plus disable: still pulls
// R16: manual mode boosts only with policy bit3
// R17: bit3 selects full or maximum duty
// R18: disable bit stops fan drive changes
// R19: pwm frequency: low options or high
// R20: three drives, third also serves fourth fan
// R21: shared pin select encodes four functions
// R22: timer accumulates, clears on read, saturates
// R23: bit0 first assertion, then 22.76 ms steps
// R24: timer above limit sets flag, alerts
// R25: overheat output open drain, pulls low only
module tafo_top #(
  parameter int TICK_CYCLES = tafo_pkg::TICK_CYC
) (
  input  wire logic                    i_core_clk,
  input  wire logic                    i_rst,
  input  wire tafo_pkg::tafo_avs_req_t i_avs,
  output logic                         o_avs_waitrequest,
  output logic [31:0]                  o_avs_readdata,
  input  wire logic                    i_ovh_ded,
  output logic                         o_ovh_ded_o,
  output logic                         o_ovh_ded_oe,
  input  wire logic                    i_shared_pin,
  output logic                         o_shared_pin_o,
  output logic                         o_shared_pin_oe,
  input  wire tafo_pkg::tafo_temp_in_t i_temp,
  input  wire tafo_pkg::tafo_fan_in_t  i_fan,
  output logic [2:0][7:0]              o_fan_duty,
  output logic                         o_timer_alert,
  output logic                         o_fourth_speed_input,
  output logic                         o_pwm_high_freq,
  output logic [2:0]                   o_pwm_low_sel
);
  import tafo_pkg::*;

  if (TICK_CYCLES < 1 || TICK_CYCLES >= (1 << PRESC_W)) begin : g_chk
    $error("TICK_CYCLES out of range");
  end

  localparam logic [PRESC_W-1:0] TICK_LAST = PRESC_W'(TICK_CYCLES - 1);

  tafo_state_t s;
  tafo_state_t next_s;

  logic       req;
  logic       take;
  logic [7:0] idx;
  logic       ded_on;
  logic       sh_on;
  logic       line_act;
  logic       rd_timer;
  logic [7:0] timer_val;
  logic       drv_ok;
  logic       ovh_any;
  logic       fan_override_bit_ok;
  logic       alert_masked;
  tafo_sel_t  sel;

  ////////////////////////////////////////////////////////////////////////////

  function automatic logic is_off64(input logic [7:0] misc);
    return misc[OFF64_BIT];
  endfunction

  // limits at the bottom of the range switch the channel off
  function automatic logic ch_disabled(input logic [7:0] lim, input logic off64);
    if (off64) begin
      return lim <= OFF64_MIN;
    end
    return lim == TWOS_MIN;
  endfunction

  // true once the reading is at least a quarter degree above the limit
  function automatic logic over_limit(input logic [9:0] t, input logic [7:0] lim,
                                      input logic off64);
    if (off64) begin
      return t > {lim, 2'b00};
    end
    return $signed(t) > $signed({lim, 2'b00});
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  assign req  = i_avs.read | i_avs.write;
  assign take = req & s.ack;
  assign idx  = i_avs.address[9:2];
  assign sel  = tafo_sel_t'(s.pin_cfg[SEL_LSB +: 2]);

  assign ded_on   = s.cfg3[TMR_EN_BIT];  // R01
  assign sh_on    = s.cfg3[TMR_EN_BIT] & (sel == TAFO_SEL_OVH);  // R02 R21
  assign line_act = (ded_on & ~s.ded_sync[1]) | (sh_on & ~s.sh_sync[1]);
  assign rd_timer = take & i_avs.read & (idx == OFF_TIMER);

  // before the first step bit0 only records that an assertion was seen
  assign timer_val = (s.units == 8'h00) ? {7'h00, s.seen} : s.units;  // R23

  // the disable bit only holds the pin while hysteresis is on
  assign drv_ok  = ~(s.pin_cfg[OVH_DIS_BIT] & ~s.hyst[HYST_OFF_BIT]);  // R13 R14 R15
  assign ovh_any = |s.ovh_ch;

  assign fan_override_bit_ok = s.cfg3[FAN_OVERRIDE_BIT_BIT] & ~s.pin_cfg[OVH_DIS_BIT]  // R18
                  & (~i_fan.manual | s.fan_policy[MANUAL_OK_BIT]);  // R16

  assign alert_masked = (ded_on & s.mask1[MASK1_TMR_BIT])
                      | (sh_on & s.mask2[MASK2_TMR_BIT]);  // R05

  always_comb begin
    next_s = s;
    next_s.ded_sync = {s.ded_sync[0], i_ovh_ded};
    next_s.sh_sync  = {s.sh_sync[0], i_shared_pin};

    // one wait cycle per access keeps the read mux off the bus path
    next_s.ack = req & ~s.ack;
    if (i_avs.read & ~s.ack) begin
      unique case (idx)
        OFF_FAN_POLICY: next_s.rdata = {24'h000000, s.fan_policy};
        OFF_HYST:       next_s.rdata = {24'h000000, s.hyst};
        OFF_CRIT_R1:    next_s.rdata = {24'h000000, s.crit[0]};  // R10
        OFF_CRIT_LOC:   next_s.rdata = {24'h000000, s.crit[1]};
        OFF_CRIT_R2:    next_s.rdata = {24'h000000, s.crit[2]};
        OFF_MASK1:      next_s.rdata = {24'h000000, s.mask1};
        OFF_MASK2:      next_s.rdata = {24'h000000, s.mask2};
        OFF_CFG3:       next_s.rdata = {24'h000000, s.cfg3};
        OFF_TIMER:      next_s.rdata = {24'h000000, timer_val};
        OFF_TLIM:       next_s.rdata = {24'h000000, s.tlim};
        OFF_OUT_EN:     next_s.rdata = {24'h000000, s.out_en};
        OFF_PIN_CFG:    next_s.rdata = {24'h000000, s.pin_cfg};
        OFF_ISR2:       next_s.rdata = {24'h000000, 2'b00, s.isr_flag, 5'h00};
        OFF_MISC:       next_s.rdata = {24'h000000, s.misc};
        default:        next_s.rdata = 32'h00000000;
      endcase
    end

    if (take & i_avs.write & i_avs.byteenable[0]) begin
      unique case (idx)
        OFF_FAN_POLICY: next_s.fan_policy = i_avs.writedata[7:0];
        OFF_HYST:       next_s.hyst       = i_avs.writedata[7:0];
        OFF_CRIT_R1:    next_s.crit[0]    = i_avs.writedata[7:0];  // R10
        OFF_CRIT_LOC:   next_s.crit[1]    = i_avs.writedata[7:0];
        OFF_CRIT_R2:    next_s.crit[2]    = i_avs.writedata[7:0];
        OFF_MASK1:      next_s.mask1      = i_avs.writedata[7:0];
        OFF_MASK2:      next_s.mask2      = i_avs.writedata[7:0];
        OFF_CFG3:       next_s.cfg3       = i_avs.writedata[7:0];
        OFF_TLIM:       next_s.tlim       = i_avs.writedata[7:0];
        OFF_OUT_EN:     next_s.out_en     = i_avs.writedata[7:0];
        OFF_PIN_CFG:    next_s.pin_cfg    = i_avs.writedata[7:0];
        OFF_MISC:       next_s.misc       = i_avs.writedata[7:0];
        default:        next_s.misc       = s.misc;
      endcase
    end

    // accumulating timer; a read restarts it but keeps a live assertion
    if (rd_timer) begin
      next_s.seen  = line_act;  // R22
      next_s.units = 8'h00;
      next_s.presc = '0;
    end else if (line_act) begin
      next_s.seen = 1'b1;
      if (s.presc == TICK_LAST) begin
        next_s.presc = '0;
        if (s.units != 8'hFF) begin
          next_s.units = s.units + 8'h01;  // R22 R23
        end
      end else begin
        next_s.presc = s.presc + PRESC_W'(1);
      end
    end

    // flag clears on its own read, but a same-cycle set wins
    if (take & i_avs.read & (idx == OFF_ISR2)) begin
      next_s.isr_flag = 1'b0;
    end
    if (timer_val > s.tlim) begin
      next_s.isr_flag = 1'b1;  // R06 R24
    end

    // each channel is judged once per monitoring cycle, so a trip lasts at least one
    if (i_temp.cycle_done) begin
      for (int i = 0; i < 3; i++) begin
        next_s.ovh_ch[i] = s.out_en[CH_EN_LSB + i]  // R11
                         & ~ch_disabled(s.crit[i], is_off64(s.misc))  // R12
                         & over_limit(i_temp.temp[i], s.crit[i], is_off64(s.misc));  // R07 R08 R09
      end
    end

    // idle fans are left idle; only a running fan is pushed up
    for (int i = 0; i < 3; i++) begin
      if (line_act & fan_override_bit_ok & (i_fan.duty[i] != 8'h00)) begin
        next_s.duty[i] = s.pin_cfg[MAX_DUTY_BIT] ? i_fan.max_duty[i] : DUTY_FULL;  // R03 R17
      end else begin
        next_s.duty[i] = i_fan.duty[i];  // R04
      end
    end

    if (i_rst) begin
      next_s          = '0;
      next_s.ded_sync = 2'b11;
      next_s.sh_sync  = 2'b11;
      next_s.cfg3     = RST_REG;
    end
  end

  always_ff @(posedge i_core_clk) begin
    s <= next_s;
  end

  ////////////////////////////////////////////////////////////////////////////

  assign o_avs_waitrequest = req & ~s.ack;
  assign o_avs_readdata    = s.rdata;

  // open drain: the data pin is always low, only the enable moves
  assign o_ovh_ded_o     = 1'b0;  // R25
  assign o_ovh_ded_oe    = ded_on & drv_ok & ovh_any;  // R25
  assign o_shared_pin_o  = 1'b0;
  assign o_shared_pin_oe = (sh_on & drv_ok & ovh_any)
                         | ((sel == TAFO_SEL_ALERT) & o_timer_alert);  // R21

  assign o_timer_alert        = s.isr_flag & ~alert_masked;  // R05 R24
  assign o_fan_duty           = s.duty;  // R20
  assign o_fourth_speed_input = (sel == TAFO_SEL_SPEED) & s.sh_sync[1];  // R20 R21
  assign o_pwm_high_freq      = s.misc[HIFREQ_BIT];  // R19
  assign o_pwm_low_sel        = s.misc[LOFREQ_LSB +: 3];  // R19

  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  property p_timer_off;  // R01
    !s.cfg3[TMR_EN_BIT] && !rd_timer |=> $stable(s.units) && $stable(s.presc);
  endproperty
  a_timer_off: assert property (p_timer_off) else $error("timer ran while disabled");  // R01

  property p_shared_gate;  // R02
    (sel == TAFO_SEL_OVH) && !s.cfg3[TMR_EN_BIT] |-> !o_shared_pin_oe;
  endproperty
  a_shared_gate: assert property (p_shared_gate) else $error("shared pin pulled");  // R02

  property p_fan_override_bit;  // R03
    line_act && s.cfg3[FAN_OVERRIDE_BIT_BIT] && !s.pin_cfg[OVH_DIS_BIT] && !s.pin_cfg[MAX_DUTY_BIT]
      && !i_fan.manual && i_fan.duty[0] != 8'h00 |=> o_fan_duty[0] == 8'hFF;
  endproperty
  a_fan_override_bit: assert property (p_fan_override_bit) else $error("running fan not boosted");  // R03

  property p_no_fan_override_bit;  // R04
    !s.cfg3[FAN_OVERRIDE_BIT_BIT] |=> o_fan_duty[1] == $past(i_fan.duty[1]);
  endproperty
  a_no_fan_override_bit: assert property (p_no_fan_override_bit) else $error("fan duty changed");  // R04

  property p_mask;  // R05
    ded_on && s.mask1[MASK1_TMR_BIT] |-> !o_timer_alert;
  endproperty
  a_mask: assert property (p_mask) else $error("masked alert raised");  // R05

  property p_zero_limit;  // R06
    s.tlim == 8'h00 && s.seen |=> s.isr_flag;
  endproperty
  a_zero_limit: assert property (p_zero_limit) else $error("zero limit did not flag");  // R06

  property p_hold_cycle;  // R09
    $rose(ovh_any) && !i_temp.cycle_done |=> ovh_any;
  endproperty
  a_hold_cycle: assert property (p_hold_cycle) else $error("overheat dropped early");  // R09

  property p_ch_off;  // R12
    i_temp.cycle_done && is_off64(s.misc) && s.crit[0] <= OFF64_MIN |=> !s.ovh_ch[0];
  endproperty
  a_ch_off: assert property (p_ch_off) else $error("disabled channel tripped");  // R12

  property p_hyst_block;  // R14
    s.pin_cfg[OVH_DIS_BIT] && !s.hyst[HYST_OFF_BIT] |-> !o_ovh_ded_oe;
  endproperty
  a_hyst_block: assert property (p_hyst_block) else $error("pin pulled while disabled");  // R14

  property p_saturate;  // R22
    s.units == 8'hFF && !rd_timer |=> s.units == 8'hFF;
  endproperty
  a_saturate: assert property (p_saturate) else $error("timer left full scale");  // R22

  property p_trip_quarter;
    i_temp.cycle_done && s.out_en[CH_EN_LSB] && !s.misc[OFF64_BIT] && !s.crit[0][7]
      && i_temp.temp[0] == {s.crit[0], 2'b01} |=> s.ovh_ch[0];
  endproperty
  a_trip_quarter: assert property (p_trip_quarter) else $error("quarter over missed");  // R07

  property p_at_limit;
    i_temp.cycle_done && i_temp.temp[0] == {s.crit[0], 2'b00} |=> !s.ovh_ch[0];
  endproperty
  a_at_limit: assert property (p_at_limit) else $error("trip at limit");  // R08

  property p_ch_enable;
    i_temp.cycle_done && !s.out_en[CH_EN_LSB + 1] |=> !s.ovh_ch[1];
  endproperty
  a_ch_enable: assert property (p_ch_enable) else $error("masked channel tripped");  // R11

  property p_hyst_off;
    s.hyst[HYST_OFF_BIT] && s.pin_cfg[OVH_DIS_BIT] && ded_on && ovh_any |-> o_ovh_ded_oe;
  endproperty
  a_hyst_off: assert property (p_hyst_off) else $error("pin not pulled");  // R13 R15

  property p_manual;
    i_fan.manual && !s.fan_policy[MANUAL_OK_BIT] |=> o_fan_duty[2] == $past(i_fan.duty[2]);
  endproperty
  a_manual: assert property (p_manual) else $error("manual fan boosted");  // R16

  property p_max_duty;
    line_act && fan_override_bit_ok && s.pin_cfg[MAX_DUTY_BIT] && i_fan.duty[2] != 8'h00
      |=> o_fan_duty[2] == $past(i_fan.max_duty[2]);
  endproperty
  a_max_duty: assert property (p_max_duty) else $error("maximum duty not used");  // R17

  property p_dis_fans;
    s.pin_cfg[OVH_DIS_BIT] |=> o_fan_duty[0] == $past(i_fan.duty[0]);
  endproperty
  a_dis_fans: assert property (p_dis_fans) else $error("disabled override moved fan");  // R18

  property p_alert_pin;
    sel == TAFO_SEL_ALERT && o_timer_alert |-> o_shared_pin_oe;
  endproperty
  a_alert_pin: assert property (p_alert_pin) else $error("alert pin idle");  // R21

  property p_flag;
    timer_val > s.tlim |=> s.isr_flag;
  endproperty
  a_flag: assert property (p_flag) else $error("timer limit flag missing");  // R24

  property p_idle_fan;
    i_fan.duty[1] == 8'h00 |=> o_fan_duty[1] == 8'h00;
  endproperty
  a_idle_fan: assert property (p_idle_fan) else $error("idle fan driven");  // R03

  c_fan_override_bit: cover property (line_act && fan_override_bit_ok ##1 o_fan_duty[0] == 8'hFF);
  c_trip:  cover property ($rose(o_ovh_ded_oe));
  c_alert: cover property ($rose(o_timer_alert));
  c_clear: cover property (rd_timer && line_act);

endmodule

// file: verif/tafo_hot_model.sv
`timescale 1ns/1ps

// processor hot driver: open drain onto a pulled-up line shared with the device
module tafo_hot_model (
  input  wire logic i_core_clk,
  input  wire logic i_hold,
  input  wire logic i_dut_oe,
  output logic      o_line
);
  logic pull = 1'b0;

  // registered like a real driver, so the line never moves on the bench's own edge
  always @(posedge i_core_clk) begin
    pull <= i_hold;
  end

  // either party pulling wins; released line returns high through the pull-up
  assign o_line = !(pull | i_dut_oe);
endmodule

// file: verif/tb_thermal_alarm_fan_override.sv
`timescale 1ns/1ps

module tb_thermal_alarm_fan_override;
  import tafo_pkg::*;
  localparam int TICKS = 4;
  localparam logic [7:0] REGS [12] = '{OFF_FAN_POLICY, OFF_HYST, OFF_CRIT_R1, OFF_CRIT_LOC,
    OFF_CRIT_R2, OFF_MASK1, OFF_MASK2, OFF_CFG3, OFF_TLIM, OFF_OUT_EN, OFF_PIN_CFG, OFF_MISC};
  logic            i_core_clk = 1'b0;
  logic            i_rst      = 1'b1;
  tafo_avs_req_t   i_avs      = '0;
  tafo_temp_in_t   i_temp     = '0;
  tafo_fan_in_t    i_fan      = '0;
  logic            hold_ded   = 1'b0;
  logic            hold_sh    = 1'b0;
  logic            ded_line, sh_line, ded_oe, sh_oe, bus_wait, alert, speed4, hifreq;
  logic [31:0]     rdata;
  logic [2:0][7:0] duty;
  logic [2:0]      losel;
  logic [31:0]     exp_q[$];
  logic [7:0]      v;
  int              err_count = 0;
  int              checked = 0;

  always #12.5 i_core_clk = ~i_core_clk;

  tafo_top #(.TICK_CYCLES(TICKS)) u_tafo_top (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_avs(i_avs), .o_avs_waitrequest(bus_wait),
    .o_avs_readdata(rdata), .i_ovh_ded(ded_line), .o_ovh_ded_o(), .o_ovh_ded_oe(ded_oe),
    .i_shared_pin(sh_line), .o_shared_pin_o(), .o_shared_pin_oe(sh_oe), .i_temp(i_temp),
    .i_fan(i_fan), .o_fan_duty(duty), .o_timer_alert(alert),
    .o_fourth_speed_input(speed4), .o_pwm_high_freq(hifreq), .o_pwm_low_sel(losel));
  tafo_hot_model u_tafo_hot_model (.i_core_clk(i_core_clk), .i_hold(hold_ded),
    .i_dut_oe(ded_oe), .o_line(ded_line));
  tafo_hot_model u_tafo_hot_model_sh (.i_core_clk(i_core_clk), .i_hold(hold_sh),
    .i_dut_oe(sh_oe), .o_line(sh_line));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // entered just after a rising edge; holds the request until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d,
                     input logic [3:0] be);
    int n;
    n = 0;
    i_avs.address    <= {idx, 2'b00};
    i_avs.read       <= !wr;
    i_avs.write      <= wr;
    i_avs.writedata  <= {24'($urandom), d};
    i_avs.byteenable <= be;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (bus_wait !== 1'b0);
    // one wait state per access, so the answer comes at the second edge
    chk("bus wait cycles", n, 32'd2);
    i_avs.read  <= 1'b0;
    i_avs.write <= 1'b0;
    // one idle edge so a following call never drives the strobe twice in a step
    @(posedge i_core_clk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 4'hF);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    exp_q.push_back({24'h0, exp});
    bus(1'b0, idx, 8'h00, 4'hF);
  endtask

  task automatic pulse(input logic sh, input int n);
    if (sh) hold_sh <= 1'b1;
    else hold_ded <= 1'b1;
    repeat (n) @(posedge i_core_clk);
    hold_sh  <= 1'b0;
    hold_ded <= 1'b0;
    repeat (5) @(posedge i_core_clk);
  endtask

  task automatic mon(input logic [9:0] t0, input logic [9:0] t1, input logic [9:0] t2);
    i_temp.temp       <= {t2, t1, t0};
    i_temp.cycle_done <= 1'b1;
    @(posedge i_core_clk);
    i_temp.cycle_done <= 1'b0;
    repeat (3) @(posedge i_core_clk);
  endtask

  task automatic settle();
    // pin sync, model register and duty register all lie inside this span
    repeat (6) @(posedge i_core_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // read results are compared where they appear, against the oldest note
  always @(posedge i_core_clk) begin
    if (i_avs.read === 1'b1 && bus_wait === 1'b0) begin
      if (exp_q.size() == 0) chk("unexpected read", 1, 0);
      else chk("readdata", rdata, exp_q.pop_front());
    end
  end

  initial begin
    #(25 * 40000);
    err_count++;
    stop_test();
  end

  initial begin
    void'($urandom(58428));
    repeat (6) @(posedge i_core_clk);
    i_rst <= 1'b0;
    @(posedge i_core_clk);
    foreach (REGS[i]) rd(REGS[i], RST_REG);
    rd(8'h05, 8'h00);
    foreach (REGS[i]) begin
      v = 8'($urandom);
      wr(REGS[i], v);
      rd(REGS[i], v);
    end
    wr(OFF_CRIT_R1, 8'h3C);
    bus(1'b1, OFF_CRIT_R1, 8'hC3, 4'hE);
    rd(OFF_CRIT_R1, 8'h3C);
    wr(OFF_TIMER, 8'h77);
    wr(8'h05, 8'h11);
    rd(8'h05, 8'h00);
    wr(OFF_MISC, 8'hB0);
    settle();
    chk("pwm high", {31'h0, hifreq}, 32'h1);
    chk("pwm low sel", {29'h0, losel}, 32'h5);
    foreach (REGS[i]) wr(REGS[i], 8'h00);
    rd(OFF_TIMER, 8'h00);
    rd(OFF_ISR2, 8'h00);
    $display("test registers done");
    // timer: off by default, then accumulate, first mark, saturate, clear on read
    pulse(1'b0, 20);
    rd(OFF_TIMER, 8'h00);
    wr(OFF_CFG3, 8'h02);
    rd(OFF_TIMER, 8'h00);
    pulse(1'b0, 10);
    pulse(1'b0, 13);
    rd(OFF_TIMER, 8'h05);
    pulse(1'b0, 2);
    rd(OFF_TIMER, 8'h01);
    rd(OFF_ISR2, 8'h20);
    rd(OFF_ISR2, 8'h00);
    pulse(1'b0, 1100);
    rd(OFF_TIMER, 8'hFF);
    rd(OFF_TIMER, 8'h00);
    rd(OFF_ISR2, 8'h20);
    $display("test timer done");
    wr(OFF_TLIM, 8'h01);
    pulse(1'b0, 2);
    chk("alert at limit", {31'h0, alert}, 32'h0);
    pulse(1'b0, 6);
    chk("alert over limit", {31'h0, alert}, 32'h1);
    wr(OFF_MASK1, 8'h01);
    chk("alert masked", {31'h0, alert}, 32'h0);
    rd(OFF_TIMER, 8'h02);
    rd(OFF_ISR2, 8'h20);
    wr(OFF_MASK1, 8'h00);
    wr(OFF_TLIM, 8'h00);
    wr(OFF_PIN_CFG, 8'h01);
    wr(OFF_MASK2, 8'h20);
    pulse(1'b1, 2);
    chk("alert masked shared", {31'h0, alert}, 32'h0);
    wr(OFF_MASK2, 8'h00);
    settle();
    chk("alert first", {31'h0, alert}, 32'h1);
    rd(OFF_ISR2, 8'h20);
    wr(OFF_PIN_CFG, 8'h00);
    $display("test alert done");
    // overheat output
    wr(OFF_OUT_EN, 8'h20);
    wr(OFF_CRIT_R1, 8'h40);
    wr(OFF_CRIT_LOC, 8'h40);
    mon({8'h40, 2'b00}, 10'h0, 10'h0);
    chk("trip at limit", {31'h0, ded_oe}, 32'h0);
    mon({8'h40, 2'b01}, 10'h0, 10'h0);
    chk("trip quarter", {31'h0, ded_oe}, 32'h1);
    repeat (20) @(posedge i_core_clk);
    chk("trip held", {31'h0, ded_oe}, 32'h1);
    chk("line low", {31'h0, ded_line}, 32'h0);
    mon({8'h40, 2'b00}, 10'h0, 10'h0);
    chk("trip release", {31'h0, ded_oe}, 32'h0);
    mon(10'h0, 10'h1FF, 10'h0);
    chk("local not enabled", {31'h0, ded_oe}, 32'h0);
    wr(OFF_OUT_EN, 8'hC0);
    mon(10'h0, 10'h1FF, 10'h0);
    chk("local enabled", {31'h0, ded_oe}, 32'h1);
    wr(OFF_OUT_EN, 8'h20);
    wr(OFF_CRIT_R1, TWOS_MIN);
    mon(10'h3FF, 10'h0, 10'h0);
    chk("twos floor", {31'h0, ded_oe}, 32'h0);
    wr(OFF_MISC, 8'h01);
    wr(OFF_CRIT_R1, OFF64_MIN);
    mon(10'h3FF, 10'h0, 10'h0);
    chk("offset floor", {31'h0, ded_oe}, 32'h0);
    wr(OFF_CRIT_R1, 8'h40);
    wr(OFF_PIN_CFG, 8'h04);
    mon(10'h3FF, 10'h0, 10'h0);
    chk("disabled hyst on", {31'h0, ded_oe}, 32'h0);
    wr(OFF_HYST, 8'h01);
    settle();
    chk("disabled hyst off", {31'h0, ded_oe}, 32'h1);
    wr(OFF_HYST, 8'h00);
    wr(OFF_PIN_CFG, 8'h01);
    settle();
    chk("shared overheat", {31'h0, sh_oe}, 32'h1);
    wr(OFF_CFG3, 8'h00);
    settle();
    chk("shared needs enable", {31'h0, sh_oe}, 32'h0);
    mon(10'h0, 10'h0, 10'h0);
    wr(OFF_PIN_CFG, 8'h00);
    settle();
    chk("speed input", {31'h0, speed4}, 32'h1);
    wr(OFF_PIN_CFG, 8'h03);
    settle();
    chk("gpio select", {31'h0, speed4}, 32'h0);
    wr(OFF_PIN_CFG, 8'h02);
    settle();
    chk("alert pin", {31'h0, sh_oe}, 32'h1);
    $display("test overheat done");
    // fan override while the processor holds the line low
    wr(OFF_PIN_CFG, 8'h00);
    i_fan.duty     <= {8'($urandom_range(1, 255)), 8'($urandom_range(1, 255)), 8'h01};
    i_fan.max_duty <= 24'($urandom);
    wr(OFF_CFG3, 8'h06);
    hold_ded <= 1'b1;
    settle();
    chk("fan_override_bit full", {8'h0, duty}, {8'h0, {3{DUTY_FULL}}});
    wr(OFF_PIN_CFG, 8'h08);
    settle();
    chk("fan_override_bit max", {8'h0, duty}, {8'h0, i_fan.max_duty});
    wr(OFF_PIN_CFG, 8'h04);
    settle();
    chk("fan_override_bit disabled", {8'h0, duty}, {8'h0, i_fan.duty});
    wr(OFF_PIN_CFG, 8'h00);
    i_fan.manual <= 1'b1;
    settle();
    chk("manual no fan_override_bit", {8'h0, duty}, {8'h0, i_fan.duty});
    wr(OFF_FAN_POLICY, 8'h08);
    settle();
    chk("manual fan_override_bit", {8'h0, duty}, {8'h0, {3{DUTY_FULL}}});
    wr(OFF_CFG3, 8'h02);
    settle();
    chk("override clear", {8'h0, duty}, {8'h0, i_fan.duty});
    wr(OFF_CFG3, 8'h06);
    i_fan.duty <= '0;
    settle();
    chk("idle fans", {8'h0, duty}, 32'h0);
    hold_ded <= 1'b0;
    settle();
    $display("test fans done");
    stop_test();
  end
endmodule
